/* logic/dpt_pkg.sv */
// Package of register map, field positions and reset values for the dual period timers.
package dpt_pkg;

  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 10;
  localparam int DATA_W = 32;
  localparam int REG_W  = 8;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_CORE_STATUS = 8'h06;
  localparam logic [7:0] IDX_CORE_IRQ    = 8'h07;
  localparam logic [7:0] IDX_FLAGS       = 8'h16;
  localparam logic [7:0] IDX_ENABLES     = 8'h17;
  localparam logic [7:0] IDX_TIMER_CTL1  = 8'h16;
  localparam logic [7:0] IDX_TIMER_CTL2  = 8'h17;
  localparam logic [7:0] BANK3_BASE      = 8'h80;
  localparam logic [7:0] IDX_PERIOD1     = 8'h40;
  localparam logic [7:0] IDX_PERIOD2     = 8'h41;
  localparam logic [7:0] IDX_COUNT1      = 8'h42;
  localparam logic [7:0] IDX_COUNT2      = 8'h43;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_PEND      = 7;
  localparam int BIT_PERIPH_EN = 3;
  localparam int BIT_T1_FLAG = 4;
  localparam int BIT_T2_FLAG = 5;
  localparam int BIT_CASCADE = 3;
  localparam int BIT_T1_CS   = 0;
  localparam int BIT_T2_CS   = 1;
  localparam int BIT_T1_RUN  = 0;
  localparam int BIT_T2_RUN  = 1;
  localparam int BIT_GIRQ_DIS = 4;

  // ----------------------------------------------------------------
  // Reset values and masks
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_CORE_IRQ     = 8'h00;
  localparam logic [7:0] RST_FLAGS        = 8'h02;
  localparam logic [7:0] RST_ENABLES      = 8'h00;
  localparam logic [7:0] RST_TIMER_CTL1   = 8'h00;
  localparam logic [7:0] RST_TIMER_CTL2   = 8'h00;
  localparam logic [7:0] RST_PERIOD       = 8'hff;
  localparam logic [7:0] TIMER_CTL2_WMASK = 8'h3f;
  localparam logic       RST_GIRQ_DIS = 1'b1;

  // ----------------------------------------------------------------
  // Timing: instruction cycle is the core clock divided by four
  // ----------------------------------------------------------------
  localparam int         CYCLE_DIV  = 4;
  localparam logic [1:0] DIV_LAST   = 2'(CYCLE_DIV - 1);

endpackage : dpt_pkg

/* logic/dpt_sync2.sv */
// Two flip-flop level synchroniser for the external timer clock pin.
`timescale 1ns/10ps
module dpt_sync2 (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic async_in,
  output logic      sync_out
);
  logic meta;

  // The first stage is read only by the second stage.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta     <= 1'b1;
      sync_out <= 1'b1;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule : dpt_sync2

/* logic/dpt_period_timer.sv */
// One 8-bit period timer: counts ticks from zero, wraps after matching its period.
`timescale 1ns/10ps
module dpt_period_timer #(
  parameter int W = 8
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         tick,
  input  wire logic         run,
  input  wire logic [W-1:0] period_value,
  input  wire logic         load,
  input  wire logic [W-1:0] load_value,
  output logic [W-1:0]      count,
  output logic              wrap
);

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= '0;
    end else if (load) begin
      count <= load_value;
    end else if (run && tick) begin
      if (count == period_value) begin
        count <= '0;
      end else begin
        count <= count + 1'b1;
      end
    end
  end

  // A wrap is only possible on a counting tick, so a stopped timer never flags.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wrap <= 1'b0;
    end else begin
      wrap <= !load && run && tick && (count == period_value);
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  wrap_to_zero_a: assert property (
    $past(run && tick && !load && count == period_value) |-> count == '0 && wrap)
    else $error("timer did not wrap to zero after period match");
  hold_stopped_a: assert property (
    !run && !load |=> $stable(count))
    else $error("stopped timer changed its count");
  no_flag_off_a: assert property (
    !$past(run) |-> !wrap)
    else $error("stopped timer raised a wrap");

endmodule : dpt_period_timer

/* logic/dpt_timers.sv */
// Dual 8-bit period timers with interrupt flags, behind an APB register slave.
`timescale 1ns/10ps
//
// Contract
// - Cascade select clear: both timers run as separate 8-bit counters.
// - Clock select clear: timer advances once per instruction cycle, core clock over four.
// - Clock select set: timer advances on each falling edge of the shared pin.
// - Each timer counts up from zero until it equals its period value.
// - The increment after a period match returns the timer to zero.
// - Each timer sets its own wrap flag when it returns to zero.
// - Per-timer enable bit lets its flag request an interrupt, or blocks it.
// - Interrupt reaches core only with peripheral enable set and global disable clear.
// - Run bit set and cascade select clear: timer advances from its source; otherwise count holds.
// - A timer with run clear never sets its flag.
// - External clock pin is synchronised before it can increment a timer.
// - Pending bit reads OR of flags ANDed with enables; writes ignored.
module dpt_timers
#(
  parameter int TIMER_W = 8
) (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [dpt_pkg::ADDR_W-1:0] paddr,
  input  wire logic [dpt_pkg::DATA_W-1:0] pwdata,
  output logic [dpt_pkg::DATA_W-1:0]      prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic                      ext_timer_clock_pin,
  output logic                           irq
);
  import dpt_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [1:0]         div_cnt;
  logic               instr_tick;
  logic               ext_timer_clock_input;
  logic               ext_prev;
  logic               ext_fall;
  logic [BIT_PEND-1:0] core_irq_ctl;
  logic [REG_W-1:0]   periph_flags;
  logic [REG_W-1:0]   periph_en;
  logic [REG_W-1:0]   timer_ctl1;
  logic [REG_W-1:0]   timer_ctl2;
  logic               global_irq_disable;
  logic [TIMER_W-1:0] period1;
  logic [TIMER_W-1:0] period2;
  logic [TIMER_W-1:0] first_timer_count;
  logic [TIMER_W-1:0] second_timer_count;
  logic               t1_wrap;
  logic               t2_wrap;
  logic               t1_tick;
  logic               t2_tick;
  logic               access;
  logic               wr;
  logic               mapped;
  logic               peripheral_irq_pending;
  logic [REG_W-1:0]   next_flags;
  logic [REG_W-1:0]   sw_clear;
  logic [REG_W-1:0]   hw_set;
  logic [REG_W-1:0]   rd_byte;
  logic               cascade_select;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic logic reg_hit(
    input logic [ADDR_W-1:0] addr,
    input logic [7:0]        idx
  );
    reg_hit = (addr[ADDR_W-1:2] == idx) && (addr[1:0] == 2'b00);
  endfunction : reg_hit

  function automatic logic any_hit(input logic [ADDR_W-1:0] addr);
    any_hit = reg_hit(addr, IDX_CORE_STATUS) || reg_hit(addr, IDX_CORE_IRQ)
           || reg_hit(addr, IDX_FLAGS) || reg_hit(addr, IDX_ENABLES)
           || reg_hit(addr, BANK3_BASE | IDX_TIMER_CTL1)
           || reg_hit(addr, BANK3_BASE | IDX_TIMER_CTL2)
           || reg_hit(addr, IDX_PERIOD1) || reg_hit(addr, IDX_PERIOD2)
           || reg_hit(addr, IDX_COUNT1) || reg_hit(addr, IDX_COUNT2);
  endfunction : any_hit

  assign access = psel && penable && pready;
  assign wr     = access && pwrite;
  assign mapped = any_hit(paddr);

  // ----------------------------------------------------------------
  // Instruction cycle enable
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt <= '0;
    end else if (div_cnt == DIV_LAST) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + 2'b01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr_tick <= 1'b0;
    end else begin
      instr_tick <= (div_cnt == DIV_LAST);
    end
  end

  // ----------------------------------------------------------------
  // External clock pin: synchronise, then detect a falling edge
  // ----------------------------------------------------------------
  dpt_sync2 u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (ext_timer_clock_pin),
    .sync_out (ext_timer_clock_input)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_prev <= 1'b1;
    end else begin
      ext_prev <= ext_timer_clock_input;
    end
  end

  // Edges closer than two core clocks apart may merge; the pin must be slower.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_fall <= 1'b0;
    end else begin
      ext_fall <= ext_prev && !ext_timer_clock_input;
    end
  end

  // ----------------------------------------------------------------
  // Timers
  // ----------------------------------------------------------------
  assign cascade_select = timer_ctl1[BIT_CASCADE];

  // The cascaded 16-bit mode is not built; counting holds while it is selected.
  assign t1_tick = !cascade_select && (timer_ctl1[BIT_T1_CS] ? ext_fall : instr_tick);
  assign t2_tick = !cascade_select && (timer_ctl1[BIT_T2_CS] ? ext_fall : instr_tick);

  dpt_period_timer #(.W(TIMER_W)) u_timer1 (
    .pclk         (pclk),
    .presetn      (presetn),
    .tick         (t1_tick),
    .run          (timer_ctl2[BIT_T1_RUN]),
    .period_value (period1),
    .load         (wr && reg_hit(paddr, IDX_COUNT1)),
    .load_value   (pwdata[TIMER_W-1:0]),
    .count        (first_timer_count),
    .wrap         (t1_wrap)
  );

  dpt_period_timer #(.W(TIMER_W)) u_timer2 (
    .pclk         (pclk),
    .presetn      (presetn),
    .tick         (t2_tick),
    .run          (timer_ctl2[BIT_T2_RUN]),
    .period_value (period2),
    .load         (wr && reg_hit(paddr, IDX_COUNT2)),
    .load_value   (pwdata[TIMER_W-1:0]),
    .count        (second_timer_count),
    .wrap         (t2_wrap)
  );

  // ----------------------------------------------------------------
  // Peripheral flags: set by hardware, cleared by writing a one
  // ----------------------------------------------------------------
  always_comb begin
    hw_set                 = '0;
    hw_set[BIT_T1_FLAG]    = t1_wrap;
    hw_set[BIT_T2_FLAG]    = t2_wrap;
    sw_clear               = (wr && reg_hit(paddr, IDX_FLAGS)) ? pwdata[REG_W-1:0] : '0;
    next_flags             = (periph_flags & ~sw_clear) | hw_set;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periph_flags <= RST_FLAGS;
    end else begin
      periph_flags <= next_flags;
    end
  end

  assign peripheral_irq_pending = |(periph_flags & periph_en);

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_irq_ctl <= RST_CORE_IRQ[BIT_PEND-1:0];
    end else if (wr && reg_hit(paddr, IDX_CORE_IRQ)) begin
      core_irq_ctl <= pwdata[BIT_PEND-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periph_en <= RST_ENABLES;
    end else if (wr && reg_hit(paddr, IDX_ENABLES)) begin
      periph_en <= pwdata[REG_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_ctl1 <= RST_TIMER_CTL1;
    end else if (wr && reg_hit(paddr, BANK3_BASE | IDX_TIMER_CTL1)) begin
      timer_ctl1 <= pwdata[REG_W-1:0];
    end
  end

  // The two overflow status bits at the top are not built and read as zero.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_ctl2 <= RST_TIMER_CTL2;
    end else if (wr && reg_hit(paddr, BANK3_BASE | IDX_TIMER_CTL2)) begin
      timer_ctl2 <= pwdata[REG_W-1:0] & TIMER_CTL2_WMASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      global_irq_disable <= RST_GIRQ_DIS;
    end else if (wr && reg_hit(paddr, IDX_CORE_STATUS)) begin
      global_irq_disable <= pwdata[BIT_GIRQ_DIS];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      period1 <= TIMER_W'(RST_PERIOD);
      period2 <= TIMER_W'(RST_PERIOD);
    end else if (wr && reg_hit(paddr, IDX_PERIOD1)) begin
      period1 <= pwdata[TIMER_W-1:0];
    end else if (wr && reg_hit(paddr, IDX_PERIOD2)) begin
      period2 <= pwdata[TIMER_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always_comb begin
    rd_byte = '0;
    if (reg_hit(paddr, IDX_CORE_STATUS)) begin
      rd_byte[BIT_GIRQ_DIS] = global_irq_disable;
    end else if (reg_hit(paddr, IDX_CORE_IRQ)) begin
      rd_byte = {peripheral_irq_pending, core_irq_ctl};
    end else if (reg_hit(paddr, IDX_FLAGS)) begin
      rd_byte = periph_flags;
    end else if (reg_hit(paddr, IDX_ENABLES)) begin
      rd_byte = periph_en;
    end else if (reg_hit(paddr, BANK3_BASE | IDX_TIMER_CTL1)) begin
      rd_byte = timer_ctl1;
    end else if (reg_hit(paddr, BANK3_BASE | IDX_TIMER_CTL2)) begin
      rd_byte = timer_ctl2;
    end else if (reg_hit(paddr, IDX_PERIOD1)) begin
      rd_byte = REG_W'(period1);
    end else if (reg_hit(paddr, IDX_PERIOD2)) begin
      rd_byte = REG_W'(period2);
    end else if (reg_hit(paddr, IDX_COUNT1)) begin
      rd_byte = REG_W'(first_timer_count);
    end else if (reg_hit(paddr, IDX_COUNT2)) begin
      rd_byte = REG_W'(second_timer_count);
    end
  end

  // ----------------------------------------------------------------
  // APB answer: one wait state, registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= '0;
      pslverr <= 1'b0;
    end else if (psel && penable && !pready) begin
      prdata  <= (!pwrite && mapped) ? DATA_W'(rd_byte) : '0;
      pslverr <= !mapped;
    end else begin
      pslverr <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt output
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= peripheral_irq_pending && core_irq_ctl[BIT_PERIPH_EN] && !global_irq_disable;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  instr_rate_a: assert property (
    instr_tick |=> !instr_tick [*3] ##1 instr_tick)
    else $error("instruction tick is not one in four clocks");

  ext_sync_a: assert property (
    ext_fall |-> $past(ext_prev, 1) && !$past(ext_timer_clock_input, 1))
    else $error("external edge counted without synchronised fall");

  flag_set_a: assert property (
    t1_wrap || t2_wrap |=> (periph_flags[BIT_T1_FLAG] || !$past(t1_wrap))
                        && (periph_flags[BIT_T2_FLAG] || !$past(t2_wrap)))
    else $error("wrap did not set its flag");

  flag_sticky_a: assert property (
    periph_flags[BIT_T1_FLAG] && !(wr && reg_hit(paddr, IDX_FLAGS) && pwdata[BIT_T1_FLAG])
      |=> periph_flags[BIT_T1_FLAG])
    else $error("timer flag dropped without a software clear");

  irq_gate_a: assert property (
    irq |-> $past(core_irq_ctl[BIT_PERIPH_EN] && !global_irq_disable))
    else $error("interrupt raised while peripheral or global gate closed");

  irq_enable_a: assert property (
    periph_flags[BIT_T1_FLAG] && periph_en[BIT_T1_FLAG] && core_irq_ctl[BIT_PERIPH_EN]
      && !global_irq_disable |=> irq)
    else $error("enabled timer flag did not raise interrupt");

  pending_read_a: assert property (
    psel && penable && !pready && !pwrite && reg_hit(paddr, IDX_CORE_IRQ)
      |=> prdata[BIT_PEND] == $past(peripheral_irq_pending))
    else $error("pending bit read wrong");

  cascade_off_a: assert property (
    !cascade_select && timer_ctl1[BIT_T1_CS] == 1'b0 && instr_tick |-> t1_tick)
    else $error("separate timer missed an instruction tick");

endmodule : dpt_timers

/* tb/dpt_ext_clk_src.sv */
// Model of the external clock source on the shared timer clock pin.
`timescale 1ns/10ps
module dpt_ext_clk_src (
  input  wire logic       pclk,
  input  wire logic       start,
  input  wire logic [7:0] pulses,
  input  wire logic [7:0] half,
  output logic            pin,
  output logic            done
);
  // ----------------------------------------------------------------
  // Burst generator
  // ----------------------------------------------------------------
  // The pin idles high between bursts, driven high by this model.
  // One process drives both outputs so that each has a single driver.
  initial begin
    pin  = 1'b1;
    done = 1'b1;
    forever begin
      @(posedge pclk iff start);
      done <= 1'b0;
      for (int i = 0; i < pulses; i++) begin
        repeat (half) @(posedge pclk);
        pin <= 1'b0;
        repeat (half) @(posedge pclk);
        pin <= 1'b1;
      end
      @(posedge pclk);
      done <= 1'b1;
      @(posedge pclk iff !start);
    end
  end
endmodule : dpt_ext_clk_src

/* tb/dpt_timers_tb.sv */
// Self-checking bench for the dual period timers.
`timescale 1ns/10ps
module dpt_timers_tb;
  import dpt_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic        start, done, pin, err;
  logic [9:0]  paddr;
  logic [31:0] pwdata, prdata, d;
  logic [7:0]  pulses, half;
  int          miscompares = 0;
  int          n_compared = 0;
  int          cycles = 0;
  // Rows of index, mask and reset value.
  logic [23:0] rows [8] = '{24'h061010, 24'h07ff00, 24'h16ff02, 24'h17ff00,
                            24'h96ff00, 24'h97ff00, 24'h40ffff, 24'h42ff00};

  dpt_timers dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_timer_clock_pin(pin), .irq(irq));
  dpt_ext_clk_src src (.pclk(pclk), .start(start), .pulses(pulses), .half(half),
    .pin(pin), .done(done));

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic wrap_up();
    $display("compared=%0d miscompares=%0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    int n = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) miscompares++;
    d = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // One idle edge keeps the next call from assigning psel in this time step.
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    apb(1'b1, idx, v);
  endtask : wr

  task automatic rchk(input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(d, exp);
  endtask : rchk

  task automatic wait_irq(input logic lvl);
    int n = 0;
    while (irq !== lvl && n < 40) begin
      @(posedge pclk);
      n++;
    end
    chk({31'h0, irq}, {31'h0, lvl});
  endtask : wait_irq

  task automatic run_src(input logic [7:0] p, input logic [7:0] h);
    int n = 0;
    pulses <= p;
    half   <= h;
    start  <= 1'b1;
    repeat (2) @(posedge pclk);
    while (done !== 1'b1 && n < 500) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 500) miscompares++;
    start <= 1'b0;
    repeat (8) @(posedge pclk);
  endtask : run_src

  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      wrap_up();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    start = 1'b0;
    pulses = 8'h00;
    half = 8'h02;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (rows[i]) begin
      apb(1'b0, rows[i][23:16], 8'h00);
      chk(d & {24'h0, rows[i][15:8]}, {24'h0, rows[i][7:0]});
    end
    apb(1'b0, 8'h3f, 8'h00);
    chk({d[30:0], err}, 32'h1);
    wr(8'h06, 8'h00);
    wr(8'h07, 8'h08);
    wr(8'h17, 8'h30);
    // Instruction-cycle count: about one step per four clocks.
    wr(8'h97, 8'h01);
    repeat (400) @(posedge pclk);
    wr(8'h97, 8'h00);
    apb(1'b0, 8'h42, 8'h00);
    chk(32'(d >= 99 && d <= 102), 32'h1);
    repeat (40) @(posedge pclk);
    rchk(8'h42, d);
    wr(8'h42, 8'hff);
    repeat (8) @(posedge pclk);
    rchk(8'h16, 32'h02);
    wr(8'h40, 8'h03);
    wr(8'h42, 8'h00);
    wr(8'h97, 8'h01);
    wait_irq(1'b1);
    wr(8'h97, 8'h00);
    // One more instruction tick lands before the stop write takes effect.
    rchk(8'h42, 32'h1);
    rchk(8'h16, 32'h12);
    rchk(8'h07, 32'h88);
    wr(8'h17, 8'h00);
    wait_irq(1'b0);
    rchk(8'h07, 32'h08);
    rchk(8'h16, 32'h12);
    wr(8'h17, 8'h30);
    wait_irq(1'b1);
    wr(8'h06, 8'h10);
    wait_irq(1'b0);
    wr(8'h06, 8'h00);
    wait_irq(1'b1);
    wr(8'h07, 8'h00);
    wait_irq(1'b0);
    wr(8'h16, 8'h10);
    rchk(8'h16, 32'h02);
    wr(8'h07, 8'h88);
    rchk(8'h07, 32'h08);
    // External pin drives timer two; timer one keeps its own count.
    wr(8'h41, 8'h04);
    wr(8'h43, 8'h00);
    wr(8'h96, 8'h02);
    wr(8'h97, 8'h02);
    run_src(8'd5, 8'd2);
    rchk(8'h43, 32'h0);
    rchk(8'h16, 32'h22);
    wait_irq(1'b1);
    wr(8'h16, 8'h20);
    wr(8'h42, 8'h00);
    wr(8'h40, 8'hff);
    wr(8'h97, 8'h03);
    run_src(8'd3, 8'd5);
    wr(8'h97, 8'h00);
    rchk(8'h43, 32'h3);
    apb(1'b0, 8'h42, 8'h00);
    chk(32'(d > 8'h03), 32'h1);
    // Cascade select holds running timer one, since the 16-bit mode is not built.
    wr(8'h42, 8'h00);
    wr(8'h96, 8'h08);
    wr(8'h97, 8'h01);
    repeat (40) @(posedge pclk);
    rchk(8'h42, 32'h0);
    wr(8'h40, 8'h03);
    wr(8'h96, 8'h00);
    wait_irq(1'b1);
    // Second reset in mid-run must drop the interrupt and clear the run bits.
    presetn <= 1'b0;
    @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    presetn <= 1'b1;
    @(posedge pclk);
    rchk(8'h97, 32'h0);
    wrap_up();
  end
endmodule : dpt_timers_tb
